/* cfgsr_pkg.sv */
// Constants and types for the configuration start-up and readback control
package cfgsr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned TIMEGEN_PERIOD_NS = 1000;
  localparam int unsigned TIMEGEN_CYCLES    = TIMEGEN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned FILTER_TICKS      = 2;
  localparam int unsigned CLEAR_TICKS       = 160;
  localparam int unsigned CLEAR_CYCLES      = CLEAR_TICKS * TIMEGEN_CYCLES;
  localparam int unsigned RECOVER_NS        = 6000;
  localparam int unsigned RECOVER_CYCLES    =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DUMMY_BITS        = 2;

  // ****************************************
  // Pin synchroniser layout
  // ****************************************
  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned PIN_DONE  = 0;
  localparam int unsigned PIN_SCLK  = 1;
  localparam int unsigned PIN_TRIG  = 2;
  localparam int unsigned PIN_PWR   = 3;
  localparam int unsigned PIN_RST   = 4;
  localparam logic [4:0]  PIN_IDLE  = 5'h19;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RB_ON_COMMAND,
    RB_ONCE,
    RB_NEVER
  } cfgsr_rb_mode_t;

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_LOAD,
    ST_START,
    ST_OUT_EN,
    ST_OPERATE,
    ST_POWER_DOWN
  } cfgsr_state_t;

  typedef enum logic [1:0] {
    RB_IDLE,
    RB_DUMMY,
    RB_FETCH,
    RB_SHIFT
  } cfgsr_rb_state_t;

endpackage

/* cfgsr_fifo.sv */
// Readback frame FIFO with valid and ready on both sides
`timescale 1ns/1ps
module cfgsr_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push       = i_in_valid && o_in_ready;
  assign pop        = o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + (AW+1)'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // Pointers wrap explicitly so a depth that is not a power of two works
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r     <= count_nxt;
      o_in_ready  <= count_nxt != (AW+1)'(DEPTH);
      o_out_valid <= count_nxt != '0;
    end
  end

endmodule

/* cfgsr_ctrl.sv */
// Post-load start-up, readback, reprogram and power-down control
`timescale 1ns/1ps
module cfgsr_ctrl #(
  parameter int unsigned CLEAR_CYCLES = cfgsr_pkg::CLEAR_CYCLES,
  parameter int unsigned FRAME_BITS   = 16,
  parameter int unsigned FRAME_COUNT  = 4,
  parameter int unsigned FIFO_DEPTH   = 16
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_ext_reset_n,
  input  wire logic                  i_power_down_n,
  input  wire logic                  i_read_trigger,
  input  wire logic                  i_config_shift_clock,
  input  wire logic                  i_done_program_pin,
  input  wire logic                  i_load_done,
  input  wire logic                  i_osc_used,
  input  wire logic                  i_done_pullup_sel,
  input  wire logic [1:0]            i_readback_mode,
  input  wire logic                  i_frame_valid,
  input  wire logic [FRAME_BITS-1:0] i_frame_data,
  output logic                       o_frame_ready,
  output logic                       o_user_logic_run,
  output logic                       o_user_reset,
  output logic                       o_outputs_enable,
  output logic                       o_done,
  output logic                       o_done_program_out,
  output logic                       o_done_program_oe_n,
  output logic                       o_done_pullup_en,
  output logic                       o_osc_enable,
  output logic                       o_osc_connect,
  output logic                       o_clear_mem,
  output logic                       o_mode_sample,
  output logic                       o_readback_active,
  output logic                       o_read_data
);

  localparam int unsigned CW  = $clog2(CLEAR_CYCLES + 1);
  localparam int unsigned TW  = $clog2(cfgsr_pkg::TIMEGEN_CYCLES + 1);
  localparam int unsigned RW  = $clog2(cfgsr_pkg::RECOVER_CYCLES + 1);
  localparam int unsigned BW  = $clog2(FRAME_BITS + 1);
  localparam int unsigned FW  = $clog2(FRAME_COUNT + 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pin_raw;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] sync3_r;
  logic [4:0] stable_r;
  logic [4:0] prev_r;
  logic       sclk_rise;
  logic       trig_rise;
  logic       dp_high;
  logic       pd_n;
  logic       rst_n;

  assign pin_raw = {i_ext_reset_n, i_power_down_n, i_read_trigger,
                    i_config_shift_clock, i_done_program_pin};

  // A level counts only once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      sync1_r  <= cfgsr_pkg::PIN_IDLE;
      sync2_r  <= cfgsr_pkg::PIN_IDLE;
      sync3_r  <= cfgsr_pkg::PIN_IDLE;
      stable_r <= cfgsr_pkg::PIN_IDLE;
      prev_r   <= cfgsr_pkg::PIN_IDLE;
    end else begin
      sync1_r  <= pin_raw;
      sync2_r  <= sync1_r;
      sync3_r  <= sync2_r;
      stable_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (stable_r & (sync2_r ^ sync3_r));
      prev_r   <= stable_r;
    end
  end

  assign sclk_rise = stable_r[cfgsr_pkg::PIN_SCLK] && !prev_r[cfgsr_pkg::PIN_SCLK];
  assign trig_rise = stable_r[cfgsr_pkg::PIN_TRIG] && !prev_r[cfgsr_pkg::PIN_TRIG];
  assign dp_high   = stable_r[cfgsr_pkg::PIN_DONE];
  assign pd_n      = stable_r[cfgsr_pkg::PIN_PWR];
  assign rst_n     = stable_r[cfgsr_pkg::PIN_RST];

  // ****************************************
  // Internal timing generator and request filter
  // ****************************************
  cfgsr_pkg::cfgsr_state_t state_r;
  cfgsr_pkg::cfgsr_state_t state_nxt;
  logic [TW-1:0] tick_cnt_r;
  logic          tick;
  logic [1:0]    filt_cnt_r;
  logic          req_src;
  logic          reprog_req;
  logic          armed_r;

  assign tick = tick_cnt_r == TW'(cfgsr_pkg::TIMEGEN_CYCLES - 1);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  // Only a high seen after done arms reprogram, so a pin held low stays harmless
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || state_r != cfgsr_pkg::ST_OPERATE) begin
      armed_r <= 1'b0;
    end else if (dp_high) begin
      armed_r <= 1'b1;
    end
  end

  assign req_src = (state_r == cfgsr_pkg::ST_OPERATE && armed_r && !dp_high)
                || (!rst_n && (state_r == cfgsr_pkg::ST_LOAD
                || state_r == cfgsr_pkg::ST_START || state_r == cfgsr_pkg::ST_OUT_EN));

  // Low must be seen on three ticks in a row: two to three tick periods
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || !req_src) begin
      filt_cnt_r <= '0;
    end else if (tick && filt_cnt_r != 2'(cfgsr_pkg::FILTER_TICKS)) begin
      filt_cnt_r <= filt_cnt_r + 2'(1);
    end
  end

  assign reprog_req = req_src && tick && filt_cnt_r == 2'(cfgsr_pkg::FILTER_TICKS);

  // ****************************************
  // Recovery from an invalid control state
  // ****************************************
  logic          rst_was_high_r;
  logic [RW-1:0] rec_cnt_r;
  logic          recover;

  assign recover = rec_cnt_r == RW'(cfgsr_pkg::RECOVER_CYCLES - 1);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      rst_was_high_r <= 1'b0;
      rec_cnt_r      <= '0;
    end else begin
      if (recover) begin
        rst_was_high_r <= 1'b0;
      end else if (rst_n) begin
        rst_was_high_r <= 1'b1;
      end
      if (rst_was_high_r && !rst_n && !dp_high && !recover) begin
        rec_cnt_r <= rec_cnt_r + RW'(1);
      end else begin
        rec_cnt_r <= '0;
      end
    end
  end

  // ****************************************
  // Configuration state machine
  // ****************************************
  logic          resume_r;
  logic          cfg_ok_r;
  logic          step;
  logic [CW-1:0] clear_cnt_r;

  // Power-up resume has no shift clock, so it steps on timer ticks
  assign step = resume_r ? tick : sclk_rise;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cfgsr_pkg::ST_CLEAR: begin
        if (clear_cnt_r == CW'(CLEAR_CYCLES - 1)) begin
          state_nxt = cfgsr_pkg::ST_LOAD;
        end
      end
      cfgsr_pkg::ST_LOAD: begin
        if (i_load_done && sclk_rise) begin
          state_nxt = cfgsr_pkg::ST_START;
        end
      end
      cfgsr_pkg::ST_START: begin
        if (step) begin
          state_nxt = cfgsr_pkg::ST_OUT_EN;
        end
      end
      cfgsr_pkg::ST_OUT_EN: begin
        if (step) begin
          state_nxt = cfgsr_pkg::ST_OPERATE;
        end
      end
      cfgsr_pkg::ST_OPERATE: begin
        state_nxt = state_r;
      end
      cfgsr_pkg::ST_POWER_DOWN: begin
        if (pd_n) begin
          state_nxt = cfg_ok_r ? cfgsr_pkg::ST_START : cfgsr_pkg::ST_CLEAR;
        end
      end
    endcase
    if (reprog_req || recover) begin
      state_nxt = cfgsr_pkg::ST_CLEAR;
    end
    if (!pd_n) begin
      state_nxt = cfgsr_pkg::ST_POWER_DOWN;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_r     <= cfgsr_pkg::ST_CLEAR;
      clear_cnt_r <= '0;
      resume_r    <= 1'b0;
      cfg_ok_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      clear_cnt_r <= (state_nxt == cfgsr_pkg::ST_CLEAR && state_r == cfgsr_pkg::ST_CLEAR)
                     ? clear_cnt_r + CW'(1) : '0;
      if (state_r == cfgsr_pkg::ST_POWER_DOWN && state_nxt == cfgsr_pkg::ST_START) begin
        resume_r <= 1'b1;
      end else if (state_nxt == cfgsr_pkg::ST_OPERATE || state_nxt == cfgsr_pkg::ST_CLEAR) begin
        resume_r <= 1'b0;
      end
      if (state_nxt == cfgsr_pkg::ST_OPERATE) begin
        cfg_ok_r <= 1'b1;
      end else if (state_nxt == cfgsr_pkg::ST_CLEAR) begin
        cfg_ok_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Start-up and pin outputs
  // ****************************************
  // Storage reset follows the synchronised reset pin, so it lags the pin by five clocks
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_user_logic_run    <= 1'b0;
      o_user_reset        <= 1'b1;
      o_outputs_enable    <= 1'b0;
      o_done              <= 1'b0;
      o_done_program_out  <= 1'b0;
      o_done_program_oe_n <= 1'b0;
      o_done_pullup_en    <= 1'b0;
      o_osc_enable        <= 1'b0;
      o_osc_connect       <= 1'b0;
      o_clear_mem         <= 1'b1;
      o_mode_sample       <= 1'b0;
    end else begin
      o_user_logic_run    <= state_nxt inside {cfgsr_pkg::ST_START, cfgsr_pkg::ST_OUT_EN,
                                               cfgsr_pkg::ST_OPERATE};
      o_user_reset        <= state_nxt != cfgsr_pkg::ST_OPERATE || !rst_n;
      o_outputs_enable    <= state_nxt inside {cfgsr_pkg::ST_OUT_EN,
                                               cfgsr_pkg::ST_OPERATE};
      o_done              <= state_nxt == cfgsr_pkg::ST_OPERATE;
      o_done_program_out  <= 1'b0;
      o_done_program_oe_n <= state_nxt inside {cfgsr_pkg::ST_OPERATE,
                                               cfgsr_pkg::ST_POWER_DOWN};
      o_done_pullup_en    <= i_done_pullup_sel && state_nxt != cfgsr_pkg::ST_CLEAR
                             && state_nxt != cfgsr_pkg::ST_POWER_DOWN;
      o_osc_enable        <= i_osc_used && !(state_nxt inside {cfgsr_pkg::ST_CLEAR,
                                               cfgsr_pkg::ST_POWER_DOWN});
      o_osc_connect       <= i_osc_used && (state_nxt inside {cfgsr_pkg::ST_START,
                             cfgsr_pkg::ST_OUT_EN, cfgsr_pkg::ST_OPERATE});
      o_clear_mem         <= state_nxt == cfgsr_pkg::ST_CLEAR;
      o_mode_sample       <= state_r == cfgsr_pkg::ST_CLEAR
                             && state_nxt == cfgsr_pkg::ST_LOAD;
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  cfgsr_pkg::cfgsr_rb_state_t rb_state_r;
  logic                  rb_used_r;
  logic                  rb_permit;
  logic [1:0]            dummy_cnt_r;
  logic [BW-1:0]         bit_cnt_r;
  logic [FW-1:0]         frame_cnt_r;
  logic [FRAME_BITS-1:0] shreg_r;
  logic                  fifo_valid;
  logic [FRAME_BITS-1:0] fifo_data;

  // Frames hold program bits and captured storage state side by side
  cfgsr_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_frame_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_frame_valid),
    .i_in_data   (i_frame_data),
    .o_in_ready  (o_frame_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (rb_state_r == cfgsr_pkg::RB_FETCH)
  );

  assign rb_permit = (i_readback_mode == 2'(cfgsr_pkg::RB_ON_COMMAND))
                  || (i_readback_mode == 2'(cfgsr_pkg::RB_ONCE) && !rb_used_r);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || state_r == cfgsr_pkg::ST_CLEAR) begin
      rb_used_r <= 1'b0;
    end else if (rb_state_r == cfgsr_pkg::RB_DUMMY) begin
      rb_used_r <= 1'b1;
    end
  end

  // Shift-clock edges that land while a frame is still missing are lost
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || state_r != cfgsr_pkg::ST_OPERATE) begin
      rb_state_r        <= cfgsr_pkg::RB_IDLE;
      dummy_cnt_r       <= '0;
      bit_cnt_r         <= '0;
      frame_cnt_r       <= '0;
      shreg_r           <= '0;
      o_read_data       <= 1'b1;
      o_readback_active <= 1'b0;
    end else begin
      unique case (rb_state_r)
        cfgsr_pkg::RB_IDLE: begin
          if (trig_rise && rb_permit) begin
            rb_state_r        <= cfgsr_pkg::RB_DUMMY;
            dummy_cnt_r       <= '0;
            frame_cnt_r       <= '0;
            o_read_data       <= 1'b1;
            o_readback_active <= 1'b1;
          end
        end
        cfgsr_pkg::RB_DUMMY: begin
          if (sclk_rise) begin
            if (dummy_cnt_r == 2'(cfgsr_pkg::DUMMY_BITS - 1)) begin
              rb_state_r <= cfgsr_pkg::RB_FETCH;
            end else begin
              dummy_cnt_r <= dummy_cnt_r + 2'(1);
            end
          end
        end
        cfgsr_pkg::RB_FETCH: begin
          if (fifo_valid) begin
            shreg_r     <= fifo_data;
            o_read_data <= !fifo_data[FRAME_BITS-1];
            bit_cnt_r   <= '0;
            rb_state_r  <= cfgsr_pkg::RB_SHIFT;
          end
        end
        cfgsr_pkg::RB_SHIFT: begin
          if (sclk_rise) begin
            if (bit_cnt_r != BW'(FRAME_BITS - 1)) begin
              shreg_r     <= {shreg_r[FRAME_BITS-2:0], 1'b0};
              o_read_data <= !shreg_r[FRAME_BITS-2];
              bit_cnt_r   <= bit_cnt_r + BW'(1);
            end else if (frame_cnt_r == FW'(FRAME_COUNT - 1)) begin
              rb_state_r        <= cfgsr_pkg::RB_IDLE;
              o_read_data       <= 1'b1;
              o_readback_active <= 1'b0;
            end else begin
              frame_cnt_r <= frame_cnt_r + FW'(1);
              rb_state_r  <= cfgsr_pkg::RB_FETCH;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_clean;
    pd_n && !reprog_req && !recover;
  endsequence
  sequence s_load_end;
    state_r == cfgsr_pkg::ST_LOAD && i_load_done && sclk_rise ##0 s_clean;
  endsequence
  sequence s_start_step;
    state_r == cfgsr_pkg::ST_START && step ##0 s_clean;
  endsequence
  sequence s_oe_step;
    state_r == cfgsr_pkg::ST_OUT_EN && step ##0 s_clean;
  endsequence

  property p_run_after_load;
    s_load_end |=> o_user_logic_run && o_user_reset && !o_outputs_enable;
  endproperty
  property p_oe_after_run;
    s_start_step |=> o_outputs_enable && !o_done && !o_done_program_oe_n;
  endproperty
  property p_done_after_oe;
    s_oe_step |=> o_done && o_done_program_oe_n;
  endproperty
  property p_osc_connect;
    o_osc_connect |-> o_osc_enable && o_user_logic_run;
  endproperty
  property p_never_refused;
    (rb_state_r == cfgsr_pkg::RB_IDLE && trig_rise
      && i_readback_mode == 2'(cfgsr_pkg::RB_NEVER)) |=> !o_readback_active;
  endproperty
  property p_rb_start;
    (rb_state_r == cfgsr_pkg::RB_IDLE && state_r == cfgsr_pkg::ST_OPERATE
      && trig_rise && rb_permit) |=> o_readback_active && o_read_data;
  endproperty
  property p_shift_inverted;
    rb_state_r == cfgsr_pkg::RB_SHIFT |-> o_read_data == !shreg_r[FRAME_BITS-1];
  endproperty
  property p_filter;
    (state_r == cfgsr_pkg::ST_OPERATE && armed_r && dp_high) ##1 !dp_high
      |-> !reprog_req [*8];
  endproperty
  property p_hold_low;
    (reprog_req && pd_n) |=> o_clear_mem && !o_done_program_oe_n && !o_outputs_enable;
  endproperty
  property p_power_down;
    !pd_n |=> !o_outputs_enable && o_done_program_oe_n && !o_user_logic_run;
  endproperty
  property p_recover;
    (recover && pd_n) |=> o_clear_mem && !o_done;
  endproperty

  a_run_after_load: assert property (p_run_after_load) else $error("no run after load");
  a_oe_after_run: assert property (p_oe_after_run) else $error("outputs not enabled");
  a_done_after_oe: assert property (p_done_after_oe) else $error("done not asserted");
  a_osc_connect: assert property (p_osc_connect) else $error("oscillator connect early");
  a_never_refused: assert property (p_never_refused) else $error("readback not refused");
  a_rb_start: assert property (p_rb_start) else $error("readback did not start");
  a_shift_inverted: assert property (p_shift_inverted) else $error("read data not inverted");
  a_filter: assert property (p_filter) else $error("short pulse accepted");
  a_hold_low: assert property (p_hold_low) else $error("done pin not held low");
  a_power_down: assert property (p_power_down) else $error("power-down outputs active");
  a_recover: assert property (p_recover) else $error("recovery missed clear");

endmodule

/* cfgsr_host.sv */
// Controller model driving the shift clock, read trigger and done wire
`timescale 1ns/1ps
module cfgsr_host (
  input  wire logic i_ref_clk,
  input  wire logic i_oe_n,
  output logic      o_sclk,
  output logic      o_trig,
  output logic      o_pin
);
  logic low_r;
  // Board pull-up holds the wire high unless either party pulls it low
  assign o_pin = i_oe_n & ~low_r;
  initial begin
    o_sclk = 1'b0;
    o_trig = 1'b0;
    low_r  = 1'b0;
  end
  // Clock stands still between transfers; 160 ns period within them
  task automatic rises(input int n);
    repeat (n) begin
      o_sclk <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      o_sclk <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
    end
  endtask
  task automatic trig();
    o_trig <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    o_trig <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
  endtask
endmodule

/* cfgsr_ctrl_tb.sv */
// Self-checking bench for the start-up, readback and reprogram control
`timescale 1ns/1ps
module cfgsr_ctrl_tb;
  logic        i_ref_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_ext_reset_n = 1'b1;
  logic        i_power_down_n = 1'b1;
  logic        i_load_done = 1'b0;
  logic        i_osc_used = 1'b1;
  logic        i_done_pullup_sel = 1'b1;
  logic [1:0]  i_readback_mode = 2'h2;
  logic        i_frame_valid = 1'b0;
  logic [15:0] i_frame_data = 16'h0;
  logic [15:0] mem [16];
  logic        sclk, trig, pin, ready, run, urst, outen, done, oe_n;
  logic        pup, osc, osc_c, clr, msamp, act, rd, dpo;
  int          errors = 0;
  int          num_checks = 0;
  int          msamp_n = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (msamp === 1'b1) msamp_n++;
  cfgsr_ctrl #(.CLEAR_CYCLES(50)) cfgsr_ctrl_i (
    .i_ref_clk, .i_reset_n, .i_ext_reset_n, .i_power_down_n,
    .i_read_trigger(trig), .i_config_shift_clock(sclk), .i_done_program_pin(pin),
    .i_load_done, .i_osc_used, .i_done_pullup_sel, .i_readback_mode,
    .i_frame_valid, .i_frame_data, .o_frame_ready(ready), .o_user_logic_run(run),
    .o_user_reset(urst), .o_outputs_enable(outen), .o_done(done),
    .o_done_program_out(dpo), .o_done_program_oe_n(oe_n), .o_done_pullup_en(pup),
    .o_osc_enable(osc), .o_osc_connect(osc_c), .o_clear_mem(clr),
    .o_mode_sample(msamp), .o_readback_active(act), .o_read_data(rd));
  cfgsr_host cfgsr_host_i (.i_ref_clk, .i_oe_n(oe_n), .o_sclk(sclk), .o_trig(trig),
    .o_pin(pin));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic boot();
    i_load_done <= 1'b1;
    cfgsr_host_i.rises(1);
    chk("run", 1'b1, run);
    chk("user_reset", 1'b1, urst);
    chk("osc_connect", 1'b1, osc_c);
    chk("out_en", 1'b0, outen);
    cfgsr_host_i.rises(1);
    chk("out_en", 1'b1, outen);
    chk("done", 1'b0, done);
    cfgsr_host_i.rises(1);
    chk("done", 1'b1, done);
    chk("oe_n", 1'b1, oe_n);
    i_load_done <= 1'b0;
  endtask
  task automatic rdbk(input int f);
    cfgsr_host_i.trig();
    cfgsr_host_i.rises(1);
    chk("rb_active", 1'b1, act);
    chk("rb_dummy", 1'b1, rd);
    cfgsr_host_i.rises(1);
    for (int w = f; w < f + 4; w++)
      for (int b = 15; b >= 0; b--) begin
        chk("rb_bit", ~mem[w][b], rd);
        cfgsr_host_i.rises(1);
      end
    chk("rb_end", 1'b0, act);
  endtask
  initial begin
    #400000;
    errors++;
    summarize();
  end
  initial begin
    for (int k = 0; k < 16; k++) mem[k] = 16'hC3A5 ^ {4{k[3:0]}};
    cyc(3);
    i_reset_n <= 1'b1;
    cyc(1);
    chk("clear", 1'b1, clr);
    cyc(60);
    chk("clear", 1'b0, clr);
    chk("mode_sample", 1'b1, msamp_n == 1);
    chk("osc_en", 1'b1, osc);
    boot();
    chk("pullup", 1'b1, pup);
    chk("user_reset", 1'b0, urst);
    i_ext_reset_n <= 1'b0;
    cyc(20);
    chk("user_reset", 1'b1, urst);
    chk("clear", 1'b0, clr);
    i_ext_reset_n <= 1'b1;
    cyc(20);
    $display("startup test done");
    // Fill the buffer until it refuses; drained by four readbacks
    for (int k = 0; k < 16; k++) begin
      i_frame_data  <= mem[k];
      i_frame_valid <= 1'b1;
      cyc(1);
      while (ready !== 1'b1) cyc(1);
    end
    i_frame_valid <= 1'b0;
    cyc(2);
    chk("frame_ready", 1'b0, ready);
    cfgsr_host_i.trig();
    chk("rb_never", 1'b0, act);
    i_readback_mode <= 2'h1;
    rdbk(0);
    cfgsr_host_i.trig();
    chk("rb_once", 1'b0, act);
    i_readback_mode <= 2'h0;
    for (int f = 4; f < 16; f += 4) rdbk(f);
    chk("frame_ready", 1'b1, ready);
    $display("readback test done");
    cfgsr_host_i.low_r <= 1'b1;
    cyc(150);
    cfgsr_host_i.low_r <= 1'b0;
    cyc(400);
    chk("clear", 1'b0, clr);
    cfgsr_host_i.low_r <= 1'b1;
    for (int i = 0; i < 400 && clr !== 1'b1; i++) cyc(1);
    chk("clear", 1'b1, clr);
    chk("oe_n", 1'b0, oe_n);
    chk("out_en", 1'b0, outen);
    cyc(60);
    chk("mode_sample", 1'b1, msamp_n == 2);
    boot();
    cfgsr_host_i.low_r <= 1'b0;
    $display("reprogram test done");
    i_power_down_n <= 1'b0;
    cyc(10);
    chk("out_en", 1'b0, outen);
    chk("run", 1'b0, run);
    chk("oe_n", 1'b1, oe_n);
    i_power_down_n <= 1'b1;
    for (int i = 0; i < 300 && outen !== 1'b1; i++) cyc(1);
    chk("user_reset", 1'b1, urst);
    chk("done", 1'b0, done);
    cyc(150);
    chk("done", 1'b1, done);
    chk("clear", 1'b0, clr);
    $display("power-down test done");
    // Reset and done wire low together long past the recovery time
    i_ext_reset_n <= 1'b0;
    cfgsr_host_i.low_r <= 1'b1;
    cyc(700);
    chk("done", 1'b0, done);
    chk("out_en", 1'b0, outen);
    i_ext_reset_n <= 1'b1;
    cfgsr_host_i.low_r <= 1'b0;
    cyc(100);
    // Power cycle while unconfigured must fall back to a full clear
    i_power_down_n <= 1'b0;
    cyc(10);
    i_power_down_n <= 1'b1;
    cyc(8);
    chk("clear", 1'b1, clr);
    cyc(60);
    boot();
    i_osc_used        <= 1'b0;
    i_done_pullup_sel <= 1'b0;
    cyc(3);
    chk("osc_en", 1'b0, osc);
    chk("osc_connect", 1'b0, osc_c);
    chk("pullup", 1'b0, pup);
    chk("dp_out", 1'b0, dpo);
    chk("done", 1'b1, done);
    $display("recovery test done");
    summarize();
  end
endmodule
